// >>> rtl/clock_bank_cfg.svh
`ifndef CLOCK_BANK_CFG_SVH
`define CLOCK_BANK_CFG_SVH
// register addresses
`define ADDR_PORT_CTL 16'h0000
`define ADDR_READBACK 16'h0004
`define ADDR_UPDATE 16'h0005
`define ADDR_SCRATCH_LO 16'h0006
`define ADDR_SCRATCH_HI 16'h0007
`define ADDR_DIE_REV 16'h000A
`define ADDR_RSVD_RO 16'h000B
`define ADDR_FAMILY_LO 16'h000C
`define ADDR_FAMILY_HI 16'h000D
`define ADDR_FB_DIV 16'h0100
`define ADDR_LOOP_SETUP 16'h0101
`define ADDR_PERIOD_LO 16'h0102
// field positions
`define BIT_SDO_ENABLE 7
`define BIT_LSB_FIRST 6
`define BIT_SOFT_RESET 5
`define BIT_READ_BUFFER 0
`define BIT_APPLY 0
`define BIT_ROM_LOADED 4
`define BIT_XTAL_ENABLE 3
`define BIT_P_DIV_HI 2
`define BIT_P_DIV_LO 1
`define BIT_DOUBLER 0
// reset values
`define PORT_CTL_RESET 8'h00
`define SCRATCH_RESET 16'h0000
`define RSVD_RO_VALUE 8'h0F
`define FB_DIV_RESET 8'h08
`define LOOP_SETUP_RESET 4'h9
`define PERIOD_LO_RESET 8'h0E
`endif

// >>> rtl/clock_bank_pkg.sv
package clock_bank_pkg;
   // register targets after address decode
   typedef enum logic [3:0] {
      REG_NONE = 4'h0,
      REG_PORT_CTL = 4'h1,
      REG_READBACK = 4'h2,
      REG_UPDATE = 4'h3,
      REG_SCRATCH_LO = 4'h4,
      REG_SCRATCH_HI = 4'h5,
      REG_DIE_REV = 4'h6,
      REG_RSVD_RO = 4'h7,
      REG_FAMILY_LO = 4'h8,
      REG_FAMILY_HI = 4'h9,
      REG_FB_DIV = 4'hA,
      REG_LOOP_SETUP = 4'hB,
      REG_PERIOD_LO = 4'hC
   } reg_id_t;
   typedef logic [7:0] byte_t;
endpackage

// >>> rtl/clock_chip_config_register_bank.sv
`timescale 1ns/1ps
`include "clock_bank_cfg.svh"

module clock_chip_config_register_bank #(
   parameter logic [7:0] DIE_REVISION = 8'hA7, // arbitrary value
   parameter logic [15:0] FAMILY_CODE = 16'h5A3C // arbitrary value
) (
   input wire logic i_clock,
   input wire logic i_rst,
   input wire logic i_two_wire_mode,
   input wire logic i_wr_en,
   input wire logic i_rd_en,
   input wire logic [15:0] i_addr,
   input wire logic [7:0] i_wdata,
   output logic [7:0] o_rdata,
   output logic o_rd_valid,
   input wire logic i_nv_valid,
   input wire logic [15:0] i_nv_addr,
   input wire logic [7:0] i_nv_data,
   output logic o_nv_ready,
   input wire logic i_rom_loaded,
   output logic o_sdo_enable,
   output logic o_lsb_first,
   output logic o_soft_reset,
   output logic [15:0] o_scratch,
   output logic [7:0] o_feedback_divider,
   output logic o_xtal_enable,
   output logic [1:0] o_p_divider,
   output logic o_doubler_enable,
   output logic [7:0] o_nominal_period_low
);

   ////////////////////////////////////////////////////////////////////////////
   // address decode, shared by host writes, nonvolatile loading and reads
   function automatic clock_bank_pkg::reg_id_t decode(input logic [15:0] a);
      case (a)
         `ADDR_PORT_CTL: decode = clock_bank_pkg::REG_PORT_CTL;
         `ADDR_READBACK: decode = clock_bank_pkg::REG_READBACK;
         `ADDR_UPDATE: decode = clock_bank_pkg::REG_UPDATE;
         `ADDR_SCRATCH_LO: decode = clock_bank_pkg::REG_SCRATCH_LO;
         `ADDR_SCRATCH_HI: decode = clock_bank_pkg::REG_SCRATCH_HI;
         `ADDR_DIE_REV: decode = clock_bank_pkg::REG_DIE_REV;
         `ADDR_RSVD_RO: decode = clock_bank_pkg::REG_RSVD_RO;
         `ADDR_FAMILY_LO: decode = clock_bank_pkg::REG_FAMILY_LO;
         `ADDR_FAMILY_HI: decode = clock_bank_pkg::REG_FAMILY_HI;
         `ADDR_FB_DIV: decode = clock_bank_pkg::REG_FB_DIV;
         `ADDR_LOOP_SETUP: decode = clock_bank_pkg::REG_LOOP_SETUP;
         `ADDR_PERIOD_LO: decode = clock_bank_pkg::REG_PERIOD_LO;
         default: decode = clock_bank_pkg::REG_NONE;
      endcase
   endfunction

   // decode results and the single write port shared by host and loader
   clock_bank_pkg::reg_id_t wr_id;
   clock_bank_pkg::reg_id_t nv_id;
   clock_bank_pkg::reg_id_t rd_id;
   clock_bank_pkg::reg_id_t w_id;
   clock_bank_pkg::byte_t w_data;
   logic w_go;
   logic nv_take;

   // storage: live registers, buffered copies and the active copies they feed
   logic [7:0] port_ctl_q;
   logic readback_q;
   logic apply_q;
   logic [15:0] scratch_q;
   logic [7:0] fb_div_buf_q;
   logic [3:0] loop_buf_q;
   logic [7:0] period_buf_q;
   logic [7:0] fb_div_q;
   logic [3:0] loop_q;
   logic [7:0] period_q;
   clock_bank_pkg::byte_t rd_byte;

   ////////////////////////////////////////////////////////////////////////////
   // write arbitration: the host wins, so a load stalls while the host writes
   assign wr_id = decode(i_addr);
   assign nv_id = decode(i_nv_addr);
   assign rd_id = decode(i_addr);
   assign o_nv_ready = !i_wr_en;
   // the port control register is excluded from loading; drop it here
   assign nv_take = i_nv_valid && !i_wr_en && (nv_id != clock_bank_pkg::REG_PORT_CTL);
   assign w_go = i_wr_en || nv_take;
   assign w_id = i_wr_en ? wr_id : nv_id;
   assign w_data = i_wr_en ? i_wdata : i_nv_data;

   ////////////////////////////////////////////////////////////////////////////
   // serial port control, live; in two-wire mode the top bits are reserved
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         port_ctl_q <= `PORT_CTL_RESET;
      end else if (w_go && w_id == clock_bank_pkg::REG_PORT_CTL) begin
         // reserved low bits are stored as their default zero
         if (i_two_wire_mode) begin
            port_ctl_q <= {2'b00, w_data[`BIT_SOFT_RESET], 5'b00000};
         end else begin
            port_ctl_q <= {w_data[`BIT_SDO_ENABLE:`BIT_SOFT_RESET], 5'b00000};
         end
      end
   end

   // readback select and scratch pad, both live
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         readback_q <= 1'b0;
         scratch_q <= `SCRATCH_RESET;
      end else if (w_go) begin
         case (w_id)
            clock_bank_pkg::REG_READBACK: readback_q <= w_data[`BIT_READ_BUFFER];
            clock_bank_pkg::REG_SCRATCH_LO: scratch_q[7:0] <= w_data;
            clock_bank_pkg::REG_SCRATCH_HI: scratch_q[15:8] <= w_data;
            default: ; // unmapped or read-only targets store nothing
         endcase
      end
   end

   // update strobe: a fresh request in the clearing cycle must not be lost
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         apply_q <= 1'b0;
      end else if (w_go && w_id == clock_bank_pkg::REG_UPDATE && w_data[`BIT_APPLY]) begin
         apply_q <= 1'b1;
      end else begin
         apply_q <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // buffered copies of the reference timing source settings
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         fb_div_buf_q <= `FB_DIV_RESET;
         loop_buf_q <= `LOOP_SETUP_RESET;
         period_buf_q <= `PERIOD_LO_RESET;
      end else if (w_go) begin
         case (w_id)
            clock_bank_pkg::REG_FB_DIV: fb_div_buf_q <= w_data;
            // load-from-rom bit is read-only and reserved bits stay zero
            clock_bank_pkg::REG_LOOP_SETUP: loop_buf_q <= w_data[3:0];
            clock_bank_pkg::REG_PERIOD_LO: period_buf_q <= w_data;
            default: ;
         endcase
      end
   end

   // active copies move only on the update strobe, all in the same edge
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         fb_div_q <= `FB_DIV_RESET;
         loop_q <= `LOOP_SETUP_RESET;
         period_q <= `PERIOD_LO_RESET;
      end else if (apply_q) begin
         fb_div_q <= fb_div_buf_q;
         loop_q <= loop_buf_q;
         period_q <= period_buf_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // read path; buffered registers show the buffer only when selected
   always_comb begin
      case (rd_id)
         clock_bank_pkg::REG_PORT_CTL: rd_byte = port_ctl_q;
         clock_bank_pkg::REG_READBACK: rd_byte = {7'b0000000, readback_q};
         clock_bank_pkg::REG_UPDATE: rd_byte = {7'b0000000, apply_q};
         clock_bank_pkg::REG_SCRATCH_LO: rd_byte = scratch_q[7:0];
         clock_bank_pkg::REG_SCRATCH_HI: rd_byte = scratch_q[15:8];
         clock_bank_pkg::REG_DIE_REV: rd_byte = DIE_REVISION;
         clock_bank_pkg::REG_RSVD_RO: rd_byte = `RSVD_RO_VALUE;
         clock_bank_pkg::REG_FAMILY_LO: rd_byte = FAMILY_CODE[7:0];
         clock_bank_pkg::REG_FAMILY_HI: rd_byte = FAMILY_CODE[15:8];
         clock_bank_pkg::REG_FB_DIV: rd_byte = readback_q ? fb_div_buf_q : fb_div_q;
         // the rom status bit is sampled live, not through the buffer
         clock_bank_pkg::REG_LOOP_SETUP: rd_byte = {3'b000, i_rom_loaded,
            readback_q ? loop_buf_q : loop_q};
         clock_bank_pkg::REG_PERIOD_LO: rd_byte = readback_q ? period_buf_q : period_q;
         default: rd_byte = 8'h00; // unmapped reads as zero
      endcase
   end

   // read data is registered; valid pulses one cycle after the request
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         o_rdata <= 8'h00;
         o_rd_valid <= 1'b0;
      end else begin
         o_rd_valid <= i_rd_en;
         if (i_rd_en) begin
            o_rdata <= rd_byte;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs to the clock logic, all straight from flip-flops
   assign o_sdo_enable = port_ctl_q[`BIT_SDO_ENABLE];
   assign o_lsb_first = port_ctl_q[`BIT_LSB_FIRST];
   assign o_soft_reset = port_ctl_q[`BIT_SOFT_RESET];
   assign o_scratch = scratch_q;
   assign o_feedback_divider = fb_div_q;
   assign o_xtal_enable = loop_q[`BIT_XTAL_ENABLE];
   assign o_p_divider = loop_q[`BIT_P_DIV_HI:`BIT_P_DIV_LO];
   assign o_doubler_enable = loop_q[`BIT_DOUBLER];
   assign o_nominal_period_low = period_q;

   ////////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (i_rst);

   logic [44:0] store_snap;
   assign store_snap = {port_ctl_q, readback_q, scratch_q, fb_div_buf_q, loop_buf_q,
      period_buf_q};

   unmapped_write_a: assert property (
      i_wr_en && wr_id == clock_bank_pkg::REG_NONE |=> $stable(store_snap) && !apply_q)
      else $error("write to an unmapped address changed state");

   readonly_read_a: assert property (
      i_rd_en && rd_id == clock_bank_pkg::REG_FAMILY_LO |=> o_rd_valid
         && o_rdata == FAMILY_CODE[7:0])
      else $error("read-only register lost its value");

   apply_clears_a: assert property (
      apply_q && !(w_go && w_id == clock_bank_pkg::REG_UPDATE && w_data[0]) |=> !apply_q)
      else $error("update strobe did not clear itself");

   nv_excluded_a: assert property (
      i_nv_valid && !i_wr_en && nv_id == clock_bank_pkg::REG_PORT_CTL |=> $stable(port_ctl_q))
      else $error("loading overwrote the excluded port control");

   live_write_a: assert property (
      i_wr_en && wr_id == clock_bank_pkg::REG_SCRATCH_HI |=> o_scratch[15:8] == $past(i_wdata))
      else $error("live scratch write did not take effect at once");

   live_status_a: assert property (
      i_rd_en && rd_id == clock_bank_pkg::REG_LOOP_SETUP |=> o_rdata[4] == $past(i_rom_loaded))
      else $error("rom status bit was not current on read");

   divider_reset_a: assert property (@(posedge i_clock) disable iff (1'b0)
      i_rst |=> o_feedback_divider == 8'h08 && fb_div_buf_q == 8'h08)
      else $error("feedback divider did not reset to eight");

   buffered_hold_a: assert property (
      i_wr_en && wr_id == clock_bank_pkg::REG_FB_DIV && !apply_q
         |=> $stable(o_feedback_divider) && fb_div_buf_q == $past(i_wdata))
      else $error("buffered write reached the active copy early");

   apply_copy_a: assert property (
      apply_q |=> o_feedback_divider == $past(fb_div_buf_q)
         && o_nominal_period_low == $past(period_buf_q))
      else $error("update strobe did not copy the buffers");

   // reads: fixed values, unmapped zero, and data that holds between reads
   reserved_fixed_a: assert property (
      i_rd_en && rd_id == clock_bank_pkg::REG_RSVD_RO |=> o_rdata == `RSVD_RO_VALUE)
      else $error("reserved read-only register changed value");

   unmapped_read_a: assert property (
      i_rd_en && rd_id == clock_bank_pkg::REG_NONE |=> o_rdata == 8'h00)
      else $error("unmapped address returned stored data");

   rdata_hold_a: assert property (
      !i_rd_en |=> $stable(o_rdata))
      else $error("read data moved without a read");

   // live writes: port control in both host modes
   port_live_a: assert property (
      i_wr_en && wr_id == clock_bank_pkg::REG_PORT_CTL && !i_two_wire_mode
         |=> {o_sdo_enable, o_lsb_first, o_soft_reset} == $past(i_wdata[7:5]))
      else $error("port control write did not take effect at once");

   two_wire_port_a: assert property (
      i_wr_en && wr_id == clock_bank_pkg::REG_PORT_CTL && i_two_wire_mode
         |=> {o_sdo_enable, o_lsb_first, o_soft_reset} == {2'b00, $past(i_wdata[5])})
      else $error("two-wire port control kept a reserved bit");

   // loading still reaches registers that are not excluded
   nv_scratch_a: assert property (
      nv_take && nv_id == clock_bank_pkg::REG_SCRATCH_LO
         |=> o_scratch[7:0] == $past(i_nv_data))
      else $error("load did not reach the scratch pad");

   // update strobe: a request always sets it, buffered writes wait for it
   apply_set_wins_a: assert property (
      w_go && w_id == clock_bank_pkg::REG_UPDATE && w_data[`BIT_APPLY] |=> apply_q)
      else $error("update request was lost");

   period_hold_a: assert property (
      i_wr_en && wr_id == clock_bank_pkg::REG_PERIOD_LO && !apply_q
         |=> $stable(o_nominal_period_low))
      else $error("buffered period write reached the active copy early");

   // main scenarios
   apply_seen_c: cover property (i_wr_en && wr_id == clock_bank_pkg::REG_UPDATE ##1 apply_q);
   nv_load_c: cover property (nv_take && w_id == clock_bank_pkg::REG_FB_DIV);
   buffer_read_c: cover property (readback_q && i_rd_en && rd_id == clock_bank_pkg::REG_FB_DIV);
   two_wire_write_c: cover property (i_wr_en && wr_id == clock_bank_pkg::REG_PORT_CTL
      && i_two_wire_mode);
   nv_stall_c: cover property (i_nv_valid && i_wr_en);

endmodule

// >>> verification/clock_chip_config_register_bank_tb.sv
`timescale 1ns/1ps
`include "clock_bank_cfg.svh"
`define CHK(n, e, s) begin num_checks++; if ((e) !== (s)) begin bad_count++; \
   $display("ERROR %s expected %h seen %h", n, e, s); end end
module clock_chip_config_register_bank_tb;
   logic clk, rst, two_wire, wr_en, rd_en, nv_valid, nv_ready, rom_loaded, rd_valid;
   logic sdo, lsb, srst, xtal, dbl;
   logic [1:0] p_div;
   logic [15:0] addr, nv_addr, scratch;
   logic [7:0] wdata, rdata, nv_data, fb_div, period_lo, v8;
   logic [31:0] lfsr_q;
   int bad_count = 0;
   int num_checks = 0;
   clock_chip_config_register_bank #(.DIE_REVISION(8'h3C), .FAMILY_CODE(16'hC35A)) u_dut (
      .i_clock(clk), .i_rst(rst), .i_two_wire_mode(two_wire), .i_wr_en(wr_en),
      .i_rd_en(rd_en), .i_addr(addr), .i_wdata(wdata), .o_rdata(rdata),
      .o_rd_valid(rd_valid), .i_nv_valid(nv_valid), .i_nv_addr(nv_addr),
      .i_nv_data(nv_data), .o_nv_ready(nv_ready), .i_rom_loaded(rom_loaded),
      .o_sdo_enable(sdo), .o_lsb_first(lsb), .o_soft_reset(srst), .o_scratch(scratch),
      .o_feedback_divider(fb_div), .o_xtal_enable(xtal), .o_p_divider(p_div),
      .o_doubler_enable(dbl), .o_nominal_period_low(period_lo));
   serial_host_model u_host (.i_clock(clk), .i_rdata(rdata), .i_rd_valid(rd_valid),
      .o_wr_en(wr_en), .o_rd_en(rd_en), .o_addr(addr), .o_wdata(wdata));
   ////////////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] next_rand(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   // two-wire hosts see the top two port-control bits as reserved zeros
   function automatic logic [2:0] exp_port(input logic m, input logic [7:0] d);
      return m ? {2'b00, d[5]} : d[7:5];
   endfunction
   task automatic rd_chk(input logic [15:0] a, input logic [7:0] e);
      logic [7:0] d;
      logic v;
      u_host.rd(a, d, v);
      `CHK("rd_valid", 1'b1, v)
      `CHK("rdata", e, d)
   endtask
   task automatic nv_load(input logic [15:0] a, input logic [7:0] d);
      @(negedge clk);
      nv_addr = a;
      nv_data = d;
      nv_valid = 1'b1;
      // the request stands until an edge finds the loader port ready
      do @(posedge clk); while (!nv_ready);
      @(negedge clk);
      nv_valid = 1'b0;
      nv_addr = ~a;
      nv_data = ~d;
   endtask
   task automatic stop_test();
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   // a hung handshake ends the run here; the full run needs well under a tenth of this
   initial begin
      #(50 * 4000);
      bad_count++;
      stop_test();
   end
   initial begin
      rst = 1'b1;
      two_wire = 1'b0;
      nv_valid = 1'b0;
      nv_addr = 16'h0000;
      nv_data = 8'h00;
      rom_loaded = 1'b0;
      lfsr_q = 32'h083A;
      repeat (4) @(posedge clk);
      @(negedge clk);
      rst = 1'b0;
      `CHK("fb_div", 8'h08, fb_div)
      `CHK("period", 8'h0E, period_lo)
      `CHK("loop", 4'h9, {xtal, p_div, dbl})
      rd_chk(`ADDR_FB_DIV, 8'h08);
      $display("test reset done");
      for (int m = 0; m < 2; m++) begin
         @(negedge clk);
         two_wire = m[0];
         u_host.wr(`ADDR_PORT_CTL, 8'hE0);
         `CHK("port", exp_port(m[0], 8'hE0), {sdo, lsb, srst})
         rd_chk(`ADDR_PORT_CTL, {exp_port(m[0], 8'hE0), 5'h00});
         u_host.wr(`ADDR_PORT_CTL, 8'h00);
      end
      two_wire = 1'b0;
      for (int i = 0; i < 4; i++) begin
         lfsr_q = next_rand(lfsr_q);
         u_host.wr(`ADDR_SCRATCH_LO, lfsr_q[7:0]);
         u_host.wr(`ADDR_SCRATCH_HI, lfsr_q[15:8]);
         `CHK("scratch", lfsr_q[15:0], scratch)
         rd_chk(`ADDR_SCRATCH_HI, lfsr_q[15:8]);
      end
      $display("test live done");
      u_host.wr(`ADDR_DIE_REV, 8'hC3);
      u_host.wr(`ADDR_RSVD_RO, 8'h00);
      u_host.wr(`ADDR_FAMILY_LO, 8'h00);
      u_host.wr(16'h0003, 8'hFF);
      u_host.wr(16'h0200, 8'hFF);
      rd_chk(`ADDR_DIE_REV, 8'h3C);
      rd_chk(`ADDR_RSVD_RO, 8'h0F);
      rd_chk(`ADDR_FAMILY_LO, 8'h5A);
      rd_chk(`ADDR_FAMILY_HI, 8'hC3);
      rd_chk(16'h0003, 8'h00);
      `CHK("scratch", lfsr_q[15:0], scratch)
      $display("test read-only done");
      v8 = {lfsr_q[23:20], 4'h3};
      u_host.wr(`ADDR_FB_DIV, v8);
      u_host.wr(`ADDR_PERIOD_LO, 8'h5C);
      u_host.wr(`ADDR_LOOP_SETUP, 8'h16);
      `CHK("fb_div", 8'h08, fb_div)
      u_host.wr(`ADDR_READBACK, 8'h01);
      rd_chk(`ADDR_FB_DIV, v8);
      u_host.wr(`ADDR_READBACK, 8'h00);
      rd_chk(`ADDR_FB_DIV, 8'h08);
      u_host.wr(`ADDR_UPDATE, 8'h01);
      @(negedge clk);
      `CHK("fb_div", v8, fb_div)
      `CHK("period", 8'h5C, period_lo)
      `CHK("loop", 4'h6, {xtal, p_div, dbl})
      rd_chk(`ADDR_UPDATE, 8'h00);
      rom_loaded = 1'b1;
      rd_chk(`ADDR_LOOP_SETUP, 8'h16);
      rom_loaded = 1'b0;
      rd_chk(`ADDR_LOOP_SETUP, 8'h06);
      $display("test update done");
      `CHK("nv_ready", 1'b1, nv_ready)
      nv_load(`ADDR_PORT_CTL, 8'hE0);
      `CHK("port", 3'b000, {sdo, lsb, srst})
      nv_load(`ADDR_SCRATCH_LO, 8'hA5);
      `CHK("scratch", 8'hA5, scratch[7:0])
      // a host write and a load in the same cycle: the load waits one cycle
      lfsr_q = next_rand(lfsr_q);
      fork
         u_host.wr(`ADDR_SCRATCH_LO, lfsr_q[7:0]);
         nv_load(`ADDR_SCRATCH_HI, lfsr_q[15:8]);
         begin
            @(negedge clk);
            @(posedge clk);
            `CHK("nv_ready", 1'b0, nv_ready)
         end
      join
      `CHK("scratch", lfsr_q[15:0], scratch)
      $display("test load done");
      @(negedge clk);
      rst = 1'b1;
      repeat (2) @(negedge clk);
      rst = 1'b0;
      `CHK("fb_div", `FB_DIV_RESET, fb_div)
      rd_chk(`ADDR_FB_DIV, `FB_DIV_RESET);
      $display("test reset again done");
      stop_test();
   end
endmodule

// >>> verification/serial_host_model.sv
`timescale 1ns/1ps
module serial_host_model (
   input wire logic i_clock,
   input wire logic [7:0] i_rdata,
   input wire logic i_rd_valid,
   output logic o_wr_en,
   output logic o_rd_en,
   output logic [15:0] o_addr,
   output logic [7:0] o_wdata
);
   initial begin
      o_wr_en = 1'b0;
      o_rd_en = 1'b0;
      o_addr = 16'h00FF;
      o_wdata = 8'h5A;
   end
   // bus is inverted after release so a stale value never passes for a live one
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(negedge i_clock);
      o_addr = a;
      // reserved fields go out as their zero defaults, except port-control bits 7:6, which pass in two-wire mode too
      o_wdata = (a == 16'h0004 || a == 16'h0005) ? (d & 8'h01) :
         (a == 16'h0000) ? (d & 8'hE0) :
         (a == 16'h0101) ? (d & 8'h1F) : d;
      o_wr_en = 1'b1;
      @(posedge i_clock);
      @(negedge i_clock);
      o_wr_en = 1'b0;
      o_addr = ~o_addr;
      o_wdata = ~o_wdata;
   endtask
   // read data and its valid flag are taken at the falling edge after the request edge
   task automatic rd(input logic [15:0] a, output logic [7:0] d, output logic v);
      @(negedge i_clock);
      o_addr = a;
      o_rd_en = 1'b1;
      @(posedge i_clock);
      @(negedge i_clock);
      o_rd_en = 1'b0;
      o_addr = ~o_addr;
      d = i_rdata;
      v = i_rd_valid;
   endtask
endmodule
